// ---- rtl/nfc_host.v ----
`include "nfc_defines.vh"

// Contract
// - Writes drive chip enable and write low with output enable high.
// - A suspended erase is restarted by an erase-resume command.
// - Time limit flag seen forces host to send a reset; the controller only sets the fail status bit and ends the poll.
// - Identification mode is left by hardware or software reset.
// - Program is two unlock cycles, A0H, then address and data.
// - Sector erase is issued as six write cycles.
module nfc_host (
    input wire sys_clk,
    input wire nrst,
    input wire [2:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg [`NFC_AW-1:0] fl_addr,
    input wire [`NFC_DW-1:0] fl_dq_in,
    output reg [`NFC_DW-1:0] fl_dq_out,
    output reg fl_dq_oe,
    output reg chip_enable_n,
    output reg write_strobe_n,
    output reg output_drive_n,
    output reg reset_n,
    input wire ready_busy_n
);
    localparam S_IDLE = 4'h0;
    localparam S_WSET = 4'h1;
    localparam S_WLOW = 4'h2;
    localparam S_WEND = 4'h3;
    localparam S_RSET = 4'h4;
    localparam S_RLOW = 4'h5;
    localparam S_RGAP = 4'h6;
    localparam S_HRST = 4'h7;
    localparam S_SWAIT = 4'h8;
    localparam S_DONE = 4'h9;
    // Integer counts cut to the timer width on purpose
    localparam integer STROBE_INT = `NFC_STROBE_CYC;
    localparam integer RP_INT = `NFC_RP_CYC;
    localparam integer SUSP_INT = `NFC_SUSP_CYC;
    localparam [`NFC_CW-1:0] STROBE_CNT = STROBE_INT[`NFC_CW-1:0];
    localparam [`NFC_CW-1:0] RP_CNT = RP_INT[`NFC_CW-1:0];
    localparam [`NFC_CW-1:0] SUSP_CNT = SUSP_INT[`NFC_CW-1:0];
    localparam [`NFC_DW-1:0] ONE_BIT = {{(`NFC_DW-1){1'b0}}, 1'b1};
    localparam [`NFC_DW-1:0] STAT_MASK = (ONE_BIT << `NFC_B_POLL) |
        (ONE_BIT << `NFC_B_TOGGLE) | (ONE_BIT << `NFC_B_TLIM) | (ONE_BIT << `NFC_B_ETMR) |
        (ONE_BIT << `NFC_B_ESTG) | (ONE_BIT << `NFC_B_BABT);

    reg [3:0] st_reg;
    reg [3:0] op_reg;
    reg [2:0] step_reg;
    reg [2:0] nsteps_reg;
    reg [`NFC_AW-1:0] addr_reg;
    reg [`NFC_DW-1:0] data_reg;
    reg [`NFC_DW-1:0] rdata_reg;
    reg [`NFC_DW-1:0] prev_reg;
    reg poll_reg;
    reg first_rd_reg;
    reg tlim_reg;
    reg busy_reg;
    reg fail_reg;
    reg ready_reg;
    reg [`NFC_DW-1:0] flags_reg;
    reg tload;
    reg [`NFC_CW-1:0] tcount;
    wire tdone;

    nfc_pulse_timer u_tmr (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .load(tload),
        .count(tcount),
        .done_reg(tdone)
    );

    // Address and data of each bus cycle in a command sequence
    function [`NFC_AW+`NFC_DW-1:0] seq_word;
        input [3:0] op;
        input [2:0] step;
        input [`NFC_AW-1:0] a;
        input [`NFC_DW-1:0] d;
        begin
            seq_word = {a, d};
            case (op)
                `NFC_OP_PROG: begin
                    case (step)
                        3'h0: seq_word = {`NFC_UNL_A1, `NFC_UNL_D1};
                        3'h1: seq_word = {`NFC_UNL_A2, `NFC_UNL_D2};
                        3'h2: seq_word = {`NFC_UNL_A1, `NFC_FL_PROG};
                        default: seq_word = {a, d};
                    endcase
                end
                `NFC_OP_SERASE: begin
                    case (step)
                        3'h0: seq_word = {`NFC_UNL_A1, `NFC_UNL_D1};
                        3'h1: seq_word = {`NFC_UNL_A2, `NFC_UNL_D2};
                        3'h2: seq_word = {`NFC_UNL_A1, `NFC_FL_ECFG};
                        3'h3: seq_word = {`NFC_UNL_A1, `NFC_UNL_D1};
                        3'h4: seq_word = {`NFC_UNL_A2, `NFC_UNL_D2};
                        default: seq_word = {a, `NFC_FL_SERASE};
                    endcase
                end
                `NFC_OP_SADD: seq_word = {a, `NFC_FL_SERASE};
                `NFC_OP_SUSP: seq_word = {a, `NFC_FL_SUSP};
                `NFC_OP_RESUME: seq_word = {a, `NFC_FL_RESUME};
                `NFC_OP_SWRST: seq_word = {a, `NFC_FL_RESET};
                default: seq_word = {a, d};
            endcase
        end
    endfunction

    function [2:0] seq_len;
        input [3:0] op;
        begin
            case (op)
                `NFC_OP_PROG: seq_len = 3'h3;
                `NFC_OP_SERASE: seq_len = 3'h5;
                default: seq_len = 3'h0;
            endcase
        end
    endfunction

    function is_write_op;
        input [3:0] op;
        begin
            is_write_op = (op == `NFC_OP_PROG) || (op == `NFC_OP_SERASE) ||
                (op == `NFC_OP_SADD) || (op == `NFC_OP_SUSP) ||
                (op == `NFC_OP_RESUME) || (op == `NFC_OP_SWRST);
        end
    endfunction

    wire [`NFC_AW+`NFC_DW-1:0] cur_word = seq_word(op_reg, step_reg, addr_reg, data_reg);
    wire toggled = (fl_dq_in[`NFC_B_TOGGLE] != prev_reg[`NFC_B_TOGGLE]);
    wire bus_wr = avs_write && !avs_waitrequest;
    // Read data are registered in the wait state, so they stand at the accepting edge
    wire bus_rd = avs_read && avs_waitrequest;
    wire start_ok = bus_wr && (avs_address == `NFC_REG_CMD) && !busy_reg;

    always @* begin
        tload = 1'b0;
        tcount = {`NFC_CW{1'b0}};
        if (st_reg == S_IDLE && start_ok && avs_writedata[3:0] == `NFC_OP_HWRST) begin
            tload = 1'b1;
            tcount = RP_CNT;
        end else if ((st_reg == S_WSET || st_reg == S_RSET) && !first_rd_reg) begin
            tload = 1'b1;
            tcount = STROBE_CNT;
        end else if (st_reg == S_RSET && first_rd_reg) begin
            tload = 1'b1;
            tcount = STROBE_CNT;
        end else if (st_reg == S_WEND && op_reg == `NFC_OP_SUSP) begin
            tload = 1'b1;
            tcount = SUSP_CNT;
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= S_IDLE;
            op_reg <= 4'h0;
            step_reg <= 3'h0;
            nsteps_reg <= 3'h0;
            addr_reg <= {`NFC_AW{1'b0}};
            data_reg <= {`NFC_DW{1'b0}};
            rdata_reg <= {`NFC_DW{1'b0}};
            prev_reg <= {`NFC_DW{1'b0}};
            poll_reg <= 1'b0;
            tlim_reg <= 1'b0;
            first_rd_reg <= 1'b0;
            busy_reg <= 1'b0;
            fail_reg <= 1'b0;
            ready_reg <= 1'b0;
            flags_reg <= {`NFC_DW{1'b0}};
            avs_readdata <= 32'h00000000;
            avs_waitrequest <= 1'b1;
            fl_addr <= {`NFC_AW{1'b0}};
            fl_dq_out <= {`NFC_DW{1'b0}};
            fl_dq_oe <= 1'b0;
            chip_enable_n <= 1'b1;
            write_strobe_n <= 1'b1;
            output_drive_n <= 1'b1;
            reset_n <= 1'b1;
        end else begin
            // One wait state per access; high again after the accepting edge
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
            end else begin
                avs_waitrequest <= 1'b1;
            end
            ready_reg <= ready_busy_n;
            if (bus_wr) begin
                case (avs_address)
                    `NFC_REG_ADDR: addr_reg <= avs_writedata[`NFC_AW-1:0];
                    `NFC_REG_DATA: data_reg <= avs_writedata[`NFC_DW-1:0];
                    default: ;
                endcase
            end
            if (bus_rd) begin
                case (avs_address)
                    `NFC_REG_ADDR: avs_readdata <= {8'h00, addr_reg};
                    `NFC_REG_DATA: avs_readdata <= {16'h0000, data_reg};
                    `NFC_REG_STAT: avs_readdata <= {27'h0000000, ready_reg, fail_reg,
                        poll_reg, 1'b0, busy_reg};
                    `NFC_REG_RDATA: avs_readdata <= {16'h0000, rdata_reg};
                    `NFC_REG_SECT: avs_readdata <= {16'h0000, flags_reg};
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
            case (st_reg)
                S_IDLE: begin
                    if (start_ok) begin
                        op_reg <= avs_writedata[3:0];
                        poll_reg <= avs_writedata[4];
                        step_reg <= 3'h0;
                        nsteps_reg <= seq_len(avs_writedata[3:0]);
                        fail_reg <= 1'b0;
                        busy_reg <= 1'b1;
                        tlim_reg <= 1'b0;
                        if (avs_writedata[3:0] == `NFC_OP_HWRST) begin
                            reset_n <= 1'b0;
                            st_reg <= S_HRST;
                        end else if (is_write_op(avs_writedata[3:0])) begin
                            st_reg <= S_WSET;
                        end else begin
                            first_rd_reg <= 1'b0;
                            st_reg <= S_RSET;
                        end
                    end
                end
                S_WSET: begin
                    // Address and data are driven on the same edge as the strobe falls
                    fl_addr <= cur_word[`NFC_AW+`NFC_DW-1:`NFC_DW];
                    fl_dq_out <= cur_word[`NFC_DW-1:0];
                    fl_dq_oe <= 1'b1;
                    output_drive_n <= 1'b1;
                    chip_enable_n <= 1'b0;
                    write_strobe_n <= 1'b0;
                    st_reg <= S_WLOW;
                end
                S_WLOW: begin
                    if (tdone) begin
                        write_strobe_n <= 1'b1;
                        chip_enable_n <= 1'b1;
                        st_reg <= S_WEND;
                    end
                end
                S_WEND: begin
                    fl_dq_oe <= 1'b0;
                    if (step_reg != nsteps_reg) begin
                        step_reg <= step_reg + 3'h1;
                        st_reg <= S_WSET;
                    end else if (op_reg == `NFC_OP_SUSP) begin
                        st_reg <= S_SWAIT;
                    end else if (poll_reg) begin
                        // Polling follows the final cycle directly
                        first_rd_reg <= 1'b1;
                        st_reg <= S_RSET;
                    end else begin
                        st_reg <= S_DONE;
                    end
                end
                S_SWAIT: begin
                    if (tdone) begin
                        st_reg <= S_DONE;
                    end
                end
                S_RSET: begin
                    fl_addr <= addr_reg;
                    fl_dq_oe <= 1'b0;
                    chip_enable_n <= 1'b0;
                    output_drive_n <= 1'b0;
                    st_reg <= S_RLOW;
                end
                S_RLOW: begin
                    if (tdone) begin
                        rdata_reg <= fl_dq_in;
                        prev_reg <= fl_dq_in;
                        flags_reg <= fl_dq_in & STAT_MASK;
                        chip_enable_n <= 1'b1;
                        output_drive_n <= 1'b1;
                        if (!poll_reg) begin
                            st_reg <= S_DONE;
                        end else if (first_rd_reg) begin
                            first_rd_reg <= 1'b0;
                            st_reg <= S_RGAP;
                        end else if (!toggled) begin
                            // Toggle stopped: operation ended or aborted
                            st_reg <= S_DONE;
                        end else if (fl_dq_in[`NFC_B_TLIM] && tlim_reg) begin
                            // Two toggling reads with the flag, not a first array word
                            fail_reg <= 1'b1;
                            st_reg <= S_DONE;
                        end else begin
                            tlim_reg <= fl_dq_in[`NFC_B_TLIM];
                            st_reg <= S_RGAP;
                        end
                    end
                end
                S_RGAP: begin
                    st_reg <= S_RSET;
                end
                S_HRST: begin
                    if (tdone) begin
                        reset_n <= 1'b1;
                        st_reg <= S_DONE;
                    end
                end
                S_DONE: begin
                    busy_reg <= 1'b0;
                    st_reg <= S_IDLE;
                end
                default: st_reg <= S_IDLE;
            endcase
        end
    end
endmodule // nfc_host

// ---- rtl/nfc_defines.vh ----
`ifndef NFC_DEFINES_VH
`define NFC_DEFINES_VH

`define NFC_AW 24
`define NFC_DW 16
// Avalon word offsets of the controller registers
`define NFC_REG_CMD 3'h0
`define NFC_REG_ADDR 3'h1
`define NFC_REG_DATA 3'h2
`define NFC_REG_STAT 3'h3
`define NFC_REG_RDATA 3'h4
`define NFC_REG_SECT 3'h5
// Command codes written to the command register
`define NFC_OP_READ 4'h1
`define NFC_OP_PROG 4'h2
`define NFC_OP_SERASE 4'h3
`define NFC_OP_SADD 4'h4
`define NFC_OP_SUSP 4'h5
`define NFC_OP_RESUME 4'h6
`define NFC_OP_SWRST 4'h7
`define NFC_OP_HWRST 4'h8
// Flash command bytes and unlock pattern
`define NFC_UNL_A1 24'h000555
`define NFC_UNL_D1 16'h00AA
`define NFC_UNL_A2 24'h0002AA
`define NFC_UNL_D2 16'h0055
`define NFC_FL_PROG 16'h00A0
`define NFC_FL_ECFG 16'h0080
`define NFC_FL_SERASE 16'h0030
`define NFC_FL_SUSP 16'h00B0
`define NFC_FL_RESUME 16'h0030
`define NFC_FL_RESET 16'h00F0
// Status bit positions on the data bus
`define NFC_B_POLL 7
`define NFC_B_TOGGLE 6
`define NFC_B_TLIM 5
`define NFC_B_ETMR 3
`define NFC_B_ESTG 2
`define NFC_B_BABT 1
// Timing, ns at a 20 ns clock
`define NFC_CLK_NS 20
`define NFC_STROBE_NS 60
`define NFC_STROBE_CYC ((`NFC_STROBE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_RP_NS 500
`define NFC_RP_CYC ((`NFC_RP_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_SUSP_NS 20000
`define NFC_SUSP_CYC ((`NFC_SUSP_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_CW 12

`endif

// ---- rtl/nfc_pulse_timer.v ----
`include "nfc_defines.vh"

module nfc_pulse_timer (
    input wire sys_clk,
    input wire nrst,
    input wire load,
    input wire [`NFC_CW-1:0] count,
    output reg done_reg
);
    reg [`NFC_CW-1:0] cnt_reg;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= {`NFC_CW{1'b0}};
            done_reg <= 1'b0;
        end else if (load) begin
            cnt_reg <= count;
            done_reg <= 1'b0;
        end else if (cnt_reg != {`NFC_CW{1'b0}}) begin
            cnt_reg <= cnt_reg - 1'b1;
            done_reg <= (cnt_reg == {{(`NFC_CW-1){1'b0}}, 1'b1});
        end else begin
            done_reg <= 1'b0;
        end
    end
endmodule // nfc_pulse_timer

// ---- testbench/nfc_host_chk.sv ----
`include "nfc_defines.vh"
module nfc_host_chk (
    input wire sys_clk,
    input wire nrst,
    input wire [`NFC_AW-1:0] fl_addr,
    input wire [`NFC_DW-1:0] fl_dq_out,
    input wire fl_dq_oe,
    input wire chip_enable_n,
    input wire write_strobe_n,
    input wire output_drive_n,
    input wire reset_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] rcnt;
    // Saturates so a stuck reset pin cannot wrap into a short pulse
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) rcnt <= 6'h00;
        else if (reset_n) rcnt <= 6'h00;
        else if (rcnt != 6'h3F) rcnt <= rcnt + 6'h01;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_wr_qual; !write_strobe_n |-> !chip_enable_n && output_drive_n && fl_dq_oe; endproperty
    a_wr_qual: assert property (p_wr_qual) else $error("bad write qualifiers");
    property p_wr_len; $fell(write_strobe_n) |-> (!write_strobe_n)[*3]; endproperty
    a_wr_len: assert property (p_wr_len) else $error("write pulse too short");
    property p_rd_len; $fell(output_drive_n) |-> (!output_drive_n && !chip_enable_n)[*3]; endproperty
    a_rd_len: assert property (p_rd_len) else $error("read pulse too short");
    property p_rd_free; !output_drive_n |-> !fl_dq_oe && write_strobe_n; endproperty
    a_rd_free: assert property (p_rd_free) else $error("bus driven during read");
    property p_hold; !write_strobe_n && $past(!write_strobe_n) |-> $stable(fl_addr) && $stable(fl_dq_out); endproperty
    a_hold: assert property (p_hold) else $error("write data moved");
    property p_pwr; $rose(nrst) |-> write_strobe_n && chip_enable_n; endproperty
    a_pwr: assert property (p_pwr) else $error("strobe low at power up");
    property p_unl; $fell(write_strobe_n) && fl_dq_out == `NFC_UNL_D1 |-> fl_addr == `NFC_UNL_A1; endproperty
    a_unl: assert property (p_unl) else $error("unlock address wrong");
    property p_rst_len; $rose(reset_n) |-> rcnt >= 6'h19; endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pulse too short");
    property p_rst_quiet; !reset_n |-> write_strobe_n && output_drive_n; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("access during reset");
    property p_susp; $fell(write_strobe_n) && fl_dq_out == `NFC_FL_SUSP |-> output_drive_n[*8]; endproperty
    a_susp: assert property (p_susp) else $error("read right after suspend");
endmodule // nfc_host_chk

// ---- testbench/nfc_flash_model.sv ----
module nfc_flash_model #(
    parameter int PROG_CYC = 40,
    parameter int ET_CYC = 100,
    parameter int ER_CYC = 400,
    parameter int SUSP_CYC = 20,
    parameter int PROT = 15
) (
    input logic sys_clk,
    input logic [23:0] fl_addr,
    input logic [15:0] fl_dq_out,
    input logic chip_enable_n,
    input logic write_strobe_n,
    input logic output_drive_n,
    input logic reset_n,
    output logic [15:0] fl_dq_in,
    output logic ready_busy_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:255];
    logic [15:0] esel = 16'h0000, lastv = 16'h0000, pd, rv;
    logic [7:0] pa, ra;
    logic we_q = 1'b1, ce_q = 1'b1, oe_q = 1'b1, rd_q = 1'b0, tgl = 1'b0, stg = 1'b0;
    int st = 0, seq = 0, cnt = 0, scnt = 0, pcnt = 0;
    wire rd = !output_drive_n && !chip_enable_n;
    wire wr = !we_q && write_strobe_n && !ce_q && oe_q && reset_n;
    wire [15:0] d = fl_dq_out;
    wire [7:0] a = fl_addr[7:0];
    wire ins = esel[a[7:4]];
    assign ready_busy_n = (st == 0 || st == 5);
    // Released bus shows the inverse of the last value, not a stale copy
    assign fl_dq_in = rd ? rv : ~lastv;
    always_comb begin
        if (st == 1 || st == 6) rv = {8'h00, ~pd[7], tgl, 6'h00};
        else if (st >= 2 && st <= 4) rv = {8'h00, 2'b00 | tgl, 2'b00, st != 2, stg & ins, 2'b00};
        else if (st == 5 && ins) rv = {8'h00, 1'b1, 4'h0, stg, 2'b00};
        else rv = mem[a];
    end
    initial for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
    always @(posedge sys_clk) begin
        we_q <= write_strobe_n;
        ce_q <= chip_enable_n;
        oe_q <= output_drive_n;
        rd_q <= rd;
        if (rd) begin
            lastv <= rv;
            ra <= a;
        end
        if (rd_q && !rd) begin
            tgl <= tgl ^ !ready_busy_n;
            if (esel[ra[7:4]]) stg <= ~stg;
        end
        if (!reset_n) begin
            st <= 0;
            seq <= 0;
            esel <= 16'h0000;
        end else case (st)
            1, 6: if (pcnt > 1) pcnt <= pcnt - 1;
                else begin
                    mem[pa] <= mem[pa] & pd;
                    st <= (st == 6) ? 5 : 0;
                end
            2: if (wr && d == 16'h0030) begin
                    esel[a[7:4]] <= 1'b1;
                    cnt <= ET_CYC;
                end else if (wr && d == 16'h00B0) st <= 5;
                else if (wr) st <= 0;
                else if (cnt > 1) cnt <= cnt - 1;
                else begin
                    st <= 3;
                    cnt <= ER_CYC;
                end
            3: if (wr && d == 16'h00B0) begin
                    st <= 4;
                    scnt <= SUSP_CYC;
                end else if (cnt > 1) cnt <= cnt - 1;
                else begin
                    for (int i = 0; i < 256; i++) if (esel[i[7:4]] && i[7:4] != PROT) mem[i] <= 16'hFFFF;
                    st <= 0;
                    esel <= 16'h0000;
                end
            4: if (scnt > 1) scnt <= scnt - 1; else st <= 5;
            default: if (wr) begin
                if (st == 5 && seq == 0 && d == 16'h0030) st <= 3;
                seq <= 0;
                case (seq)
                    0, 4: if (d == 16'h00AA && fl_addr[11:0] == 12'h555) seq <= seq + 1;
                    1, 5: if (d == 16'h0055 && fl_addr[11:0] == 12'h2AA) seq <= seq + 1;
                    2: seq <= (d == 16'h00A0) ? 3 : (d == 16'h0080 && st == 0) ? 4 : 0;
                    3: begin
                        pa <= a;
                        pd <= d;
                        pcnt <= PROG_CYC;
                        st <= (st == 5) ? 6 : 1;
                    end
                    6: if (d == 16'h0030) begin
                        esel[a[7:4]] <= 1'b1;
                        cnt <= ET_CYC;
                        st <= 2;
                    end
                    default: seq <= 0;
                endcase
            end
        endcase
    end
endmodule // nfc_flash_model

// ---- testbench/nor_flash_command_sequencer_test.sv ----
`include "nfc_defines.vh"
module nor_flash_command_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
        $display("CHECK FAILED %0t: got %h exp %h", $time, g, e); end end
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, r;
    logic avs_waitrequest, fl_dq_oe, chip_enable_n, write_strobe_n, output_drive_n;
    logic reset_n, ready_busy_n;
    logic [23:0] fl_addr;
    logic [15:0] fl_dq_in, fl_dq_out, r16;
    int err_count = 0, checks_done = 0, cyc = 0;
    always #10 sys_clk = ~sys_clk;
    nfc_host dut_u (.sys_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .fl_addr, .fl_dq_in, .fl_dq_out, .fl_dq_oe,
        .chip_enable_n, .write_strobe_n, .output_drive_n, .reset_n, .ready_busy_n);
    nfc_flash_model model_u (.sys_clk, .fl_addr, .fl_dq_out, .chip_enable_n, .write_strobe_n,
        .output_drive_n, .reset_n, .fl_dq_in, .ready_busy_n);
    task automatic bus(input logic [2:0] a, input logic rd, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wait_stat(input int b, input logic v);
        int n;
        n = 0;
        do begin
            bus(`NFC_REG_STAT, 1'b1, 32'h0);
            n++;
        end while (r[b] !== v && n < 1000);
        `CHK(r[b], v)
    endtask
    task automatic op(input logic [23:0] a, input logic [15:0] d, input logic [7:0] c);
        bus(`NFC_REG_ADDR, 1'b0, {8'h00, a});
        bus(`NFC_REG_DATA, 1'b0, {16'h0000, d});
        bus(`NFC_REG_CMD, 1'b0, {24'h000000, c});
        wait_stat(0, 1'b0);
    endtask
    task automatic frd(input logic [23:0] a);
        op(a, 16'h0000, 8'h01);
        bus(`NFC_REG_RDATA, 1'b1, 32'h0);
        r16 = r[15:0];
    endtask
    task automatic wait_run(input logic [23:0] a);
        int n;
        n = 0;
        do begin
            frd(a);
            n++;
        end while (r16[3] !== 1'b1 && n < 100);
        `CHK(r16[3], 1'b1)
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        bus(3'h7, 1'b1, 32'h0);
        `CHK(r, 32'h00000000)
        frd(24'h000012);
        `CHK(r16, 16'hFFFF)
        op(24'h000012, 16'h5A3C, 8'h12);
        `CHK(r[3], 1'b0)
        frd(24'h000012);
        `CHK(r16, 16'h5A3C)
        op(24'h000012, 16'hF00F, 8'h12);
        frd(24'h000012);
        `CHK(r16, 16'h500C)
        op(24'h000015, 16'h0000, 8'h13);
        `CHK(r[3], 1'b0)
        frd(24'h000012);
        `CHK(r16, 16'hFFFF)
        // Two sectors plus a protected one in one accumulation window
        op(24'h000020, 16'h0000, 8'h12);
        op(24'h000030, 16'h0000, 8'h12);
        op(24'h0000F1, 16'h1234, 8'h12);
        op(24'h000020, 16'h0000, 8'h03);
        op(24'h000030, 16'h0000, 8'h04);
        op(24'h0000F0, 16'h0000, 8'h04);
        wait_stat(4, 1'b1);
        frd(24'h000020);
        `CHK(r16, 16'hFFFF)
        frd(24'h000030);
        `CHK(r16, 16'hFFFF)
        frd(24'h0000F1);
        `CHK(r16, 16'h1234)
        // Foreign command inside the window aborts
        op(24'h000040, 16'h0000, 8'h12);
        op(24'h000040, 16'h0000, 8'h03);
        `CHK(r[4], 1'b0)
        frd(24'h000041);
        `CHK(r16[7], 1'b0)
        `CHK(r16[3], 1'b0)
        op(24'h000000, 16'h0000, 8'h07);
        wait_stat(4, 1'b1);
        frd(24'h000040);
        `CHK(r16, 16'h0000)
        // Hardware reset in a running erase
        op(24'h000040, 16'h0000, 8'h03);
        wait_run(24'h000041);
        op(24'h000000, 16'h0000, 8'h08);
        wait_stat(4, 1'b1);
        frd(24'h000040);
        `CHK(r16, 16'h0000)
        // Suspend, program elsewhere, resume
        op(24'h000060, 16'h0000, 8'h12);
        op(24'h000060, 16'h0000, 8'h03);
        wait_run(24'h000061);
        op(24'h000000, 16'h0000, 8'h05);
        frd(24'h000061);
        `CHK(r16[7:6], 2'b10)
        bus(`NFC_REG_SECT, 1'b1, 32'h0);
        `CHK(r[7:6], 2'b10)
        op(24'h000050, 16'hA5A5, 8'h12);
        frd(24'h000050);
        `CHK(r16, 16'hA5A5)
        op(24'h000000, 16'h0000, 8'h16);
        frd(24'h000060);
        `CHK(r16, 16'hFFFF)
        report_and_stop();
    end
endmodule // nor_flash_command_sequencer_test
bind nfc_host nfc_host_chk chk_u (.sys_clk, .nrst, .fl_addr, .fl_dq_out, .fl_dq_oe,
    .chip_enable_n, .write_strobe_n, .output_drive_n, .reset_n);
